// ===== hdl/mat_params.svh
// constants for the monitor alarm and fast-trip flag bank
// assumes inclusion by the design modules by bare name; mat_pkg.sv does not include it
`ifndef MAT_PARAMS_SVH
`define MAT_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define MAT_ADDR_RSVD_EXT    8'h6f
`define MAT_ADDR_ALARM_PRI   8'h70
`define MAT_ADDR_ALARM_SEC   8'h71
`define MAT_ADDR_RSVD_GAP    8'h72
`define MAT_ADDR_TRIP        8'h73

////////////////////////////////////////////////////////////////////////////////
// mask table bytes and select bit
`define MAT_MASK_FIRST_BYTE  8'hf8
`define MAT_MASK_LAST_BYTE   8'hfb
`define MAT_MASK_SEL_BYTE    8'hda
`define MAT_MASK_SEL_BIT     0

////////////////////////////////////////////////////////////////////////////////
// field positions
`define MAT_SEC_HI_BIT       7
`define MAT_SEC_LO_BIT       6
`define MAT_SEC_IRQ_BIT      0
`define MAT_TRIP_BITS        5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define MAT_TRIP_RESET       8'h00
`define MAT_READ_IDLE        8'h00

`endif

// ===== hdl/mat_pkg.sv
// types shared by the alarm and fast-trip flag bank
// assumes mat_params.svh is on the include path
package mat_pkg;
    typedef logic [15:0] mat_word_t;
    typedef logic [7:0]  mat_byte_t;
    // fast-trip flag order, bit 4 downward
    typedef struct packed {
        logic bias_warn_trip;
        logic bias_alarm_trip;
        logic signal_loss_trip;
        logic tx_power_low_trip;
        logic tx_power_high_trip;
    } mat_trip_t;
endpackage : mat_pkg

// ===== hdl/mat_trip_if.sv
// carrier between the flag bank and its fast-trip latch
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface mat_trip_if;
    logic              latch_mode;
    logic              clear_wr;
    logic [4:0]        clear_data;
    mat_pkg::mat_trip_t flags;

    modport trip (input latch_mode, input clear_wr, input clear_data, output flags);
    modport bank (output latch_mode, output clear_wr, output clear_data, input flags);
endinterface : mat_trip_if

// ===== hdl/mat_trip.sv
// fast-trip comparator synchroniser and flag latch
// assumes comparator levels arrive asynchronously from analog pins
`timescale 1ns/1ps
`include "mat_params.svh"
module mat_trip (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // raw comparator levels, bit 0 high power .. bit 4 bias warning
    input  wire logic [4:0] cmp_raw,
    // bank side
    mat_trip_if.trip        tif
);
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] flags_q;
    logic [4:0] next_flags;

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= cmp_raw;
            sync_b <= sync_a;
        end
    end

    // latched flags: write of 0 clears, a live trip in the same cycle wins
    always_comb begin
        if (!tif.latch_mode) begin
            next_flags = sync_b;
        end else if (tif.clear_wr) begin
            next_flags = (flags_q & tif.clear_data) | sync_b;
        end else begin
            next_flags = flags_q | sync_b;
        end
    end

    // flag register
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= 5'(`MAT_TRIP_RESET);
        end else begin
            flags_q <= next_flags;
        end
    end

    assign tif.flags = flags_q;
endmodule : mat_trip

// ===== hdl/mat_flag_bank.sv
// alarm flag bank, masked interrupt and fast-trip flag byte
// assumes measurements, limits, warnings and masks come from logic on clk;
// the register port is the device's internal memory port behind the serial interface
`timescale 1ns/1ps
`include "mat_params.svh"
module mat_flag_bank #(
    parameter int CHANNELS = 5
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,

    // conversion results, channel 0 temperature (signed),
    // 1 supply, 2 input one, 3 input two, 4 third_monitor_input
    input  wire logic [CHANNELS-1:0]        conv_done,
    input  wire mat_pkg::mat_word_t [CHANNELS-1:0] meas,
    input  wire mat_pkg::mat_word_t [CHANNELS-1:0] limit_high,
    input  wire mat_pkg::mat_word_t [CHANNELS-1:0] limit_low,

    // warning bytes kept elsewhere, [7:0] first byte, [15:8] second
    input  wire logic [15:0]                warn_flags,

    // mask tables, byte F8h in [7:0] .. FBh in [31:24]
    input  wire logic [31:0]                mask_table_a,
    input  wire logic [31:0]                mask_table_b,
    input  wire logic                       mask_select,

    // fast-trip comparators (asynchronous) and latch mode
    input  wire logic [4:0]                 trip_cmp,
    input  wire logic                       trip_latch_mode,

    // register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_rd,
    input  wire logic                       reg_wr,
    input  wire logic [7:0]                 reg_wdata,
    output logic [7:0]                      reg_rdata,
    output logic                            reg_rvalid,

    // status outputs
    output logic                            masked_irq_out,
    output logic [CHANNELS-1:0]             chan_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [CHANNELS-1:0] alarm_high;
    logic [CHANNELS-1:0] alarm_low;
    logic [CHANNELS-1:0] valid_q;
    logic [7:0]          alarm_primary;
    logic [7:0]          alarm_secondary;
    logic [7:0]          trip_byte;
    logic [31:0]         mask_active;
    logic                irq_q;
    logic                next_irq;
    logic [7:0]          next_rdata;
    logic                next_rvalid;
    logic                trip_wr;

    mat_trip_if tif ();

    ////////////////////////////////////////////////////////////////////////////
    // per-channel limit comparison

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            logic above;
            logic below;

            // temperature is two's complement, the rest unsigned
            always_comb begin
                if (g == 0) begin
                    above = $signed(meas[g]) > $signed(limit_high[g]);
                    below = $signed(meas[g]) < $signed(limit_low[g]);
                end else begin
                    above = meas[g] > limit_high[g];
                    below = meas[g] < limit_low[g];
                end
            end

            // flags follow each finished conversion, held in between
            always_ff @(posedge clk) begin
                if (rst) begin
                    alarm_high[g] <= 1'b0;
                    alarm_low[g]  <= 1'b0;
                end else if (conv_done[g]) begin
                    alarm_high[g] <= above;
                    alarm_low[g]  <= below;
                end
            end

            // a channel's flags mean nothing until its first conversion
            always_ff @(posedge clk) begin
                if (rst) begin
                    valid_q[g] <= 1'b0;
                end else if (conv_done[g]) begin
                    valid_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // alarm byte images, invalid channels read 0

    // first alarm byte: temperature, supply, input one, input two
    assign alarm_primary[7] = alarm_high[0] & valid_q[0];
    assign alarm_primary[6] = alarm_low[0]  & valid_q[0];
    assign alarm_primary[5] = alarm_high[1] & valid_q[1];
    assign alarm_primary[4] = alarm_low[1]  & valid_q[1];
    assign alarm_primary[3] = alarm_high[2] & valid_q[2];
    assign alarm_primary[2] = alarm_low[2]  & valid_q[2];
    assign alarm_primary[1] = alarm_high[3] & valid_q[3];
    assign alarm_primary[0] = alarm_low[3]  & valid_q[3];

    // second alarm byte: third input, reserved zeros, interrupt
    always_comb begin
        alarm_secondary                   = 8'h00;
        alarm_secondary[`MAT_SEC_HI_BIT]  = alarm_high[4] & valid_q[4];
        alarm_secondary[`MAT_SEC_LO_BIT]  = alarm_low[4]  & valid_q[4];
        alarm_secondary[`MAT_SEC_IRQ_BIT] = irq_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // masked interrupt

    // table choice follows the select bit; a mask bit of 1 hides its flag
    assign mask_active = mask_select ? mask_table_b : mask_table_a;

    // interrupt bit itself and reserved bits never feed back
    always_comb begin
        next_irq = |(alarm_primary & ~mask_active[7:0])
                 | |(alarm_secondary & 8'hc0 & ~mask_active[15:8])
                 | |(warn_flags[7:0] & ~mask_active[23:16])
                 | |(warn_flags[15:8] & ~mask_active[31:24]);
    end

    // interrupt register, all masked gives a steady 0
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fast-trip latch

    assign trip_wr        = reg_wr && (reg_addr == `MAT_ADDR_TRIP);
    assign tif.latch_mode = trip_latch_mode;
    assign tif.clear_wr   = trip_wr;
    assign tif.clear_data = reg_wdata[4:0];

    mat_trip u_trip (
        .clk     (clk),
        .rst     (rst),
        .cmp_raw (trip_cmp),
        .tif     (tif.trip)
    );

    // top bits forced to zero
    assign trip_byte = {3'b000, tif.flags};

    ////////////////////////////////////////////////////////////////////////////
    // register read

    // reserved and unmapped offsets read 00h; writes elsewhere are dropped
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata  = `MAT_READ_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                `MAT_ADDR_ALARM_PRI: next_rdata = alarm_primary;
                `MAT_ADDR_ALARM_SEC: next_rdata = alarm_secondary;
                `MAT_ADDR_TRIP:      next_rdata = trip_byte;
                `MAT_ADDR_RSVD_EXT:  next_rdata = `MAT_READ_IDLE;
                `MAT_ADDR_RSVD_GAP:  next_rdata = `MAT_READ_IDLE;
                default:             next_rdata = `MAT_READ_IDLE;
            endcase
        end
    end

    // read data register, answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= `MAT_READ_IDLE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status outputs

    // interrupt pin mirrors the register bit
    always_ff @(posedge clk) begin
        if (rst) begin
            masked_irq_out <= 1'b0;
        end else begin
            masked_irq_out <= next_irq;
        end
    end

    // channel-valid view for the rest of the device
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_valid <= '0;
        end else begin
            chan_valid <= valid_q | conv_done;
        end
    end

endmodule : mat_flag_bank

// ===== verification/mat_flag_bank_chk.sv
// assertions on the ports of the alarm and fast-trip flag bank
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
module mat_flag_bank_chk #(
    parameter int CHANNELS = 5
) (
    // clock and reset
    input wire logic                                clk,
    input wire logic                                rst,
    // conversion side
    input wire logic [CHANNELS-1:0]                 conv_done,
    input wire mat_pkg::mat_word_t [CHANNELS-1:0]   meas,
    input wire mat_pkg::mat_word_t [CHANNELS-1:0]   limit_high,
    input wire mat_pkg::mat_word_t [CHANNELS-1:0]   limit_low,
    input wire logic [31:0]                         mask_table_a,
    input wire logic [31:0]                         mask_table_b,
    // register port and status
    input wire logic [7:0]                          reg_addr,
    input wire logic                                reg_rd,
    input wire logic [7:0]                          reg_rdata,
    input wire logic                                reg_rvalid,
    input wire logic                                masked_irq_out,
    input wire logic [CHANNELS-1:0]                 chan_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // alarm flags and channel validity
    a_reset_quiet: assert property ($fell(rst) |-> !masked_irq_out && chan_valid == '0)
        else $error("status not cleared by reset");
    a_valid_cause: assert property ((chan_valid & ~$past(chan_valid) & ~$past(conv_done)) == '0)
        else $error("channel valid without conversion");
    a_temp_high: assert property (conv_done[0] ##1 (reg_rd && reg_addr == 8'h70) |=>
        reg_rdata[7] == $past($signed(meas[0]) > $signed(limit_high[0]), 2)) else $error("temp high flag");
    a_temp_low: assert property (conv_done[0] ##1 (reg_rd && reg_addr == 8'h70) |=>
        reg_rdata[6] == $past($signed(meas[0]) < $signed(limit_low[0]), 2)) else $error("temp low flag");
    // second alarm byte is read after the first, three edges past the conversion
    a_in3_high: assert property (conv_done[4] ##3 (reg_rd && reg_addr == 8'h71) |=>
        reg_rdata[7] == $past(meas[4] > limit_high[4], 4)) else $error("input three high flag");

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and fast-trip byte
    a_irq_bit: assert property (reg_rvalid && $past(reg_addr) == 8'h71 |->
        reg_rdata[0] == $past(masked_irq_out)) else $error("interrupt bit differs from output");
    a_masked_quiet: assert property ((mask_table_a == '1 && mask_table_b == '1) [*3] |->
        !masked_irq_out) else $error("interrupt with every flag masked");
    a_trip_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h73 |->
        reg_rdata[7:5] == 3'h0) else $error("fast-trip upper bits set");
endmodule : mat_flag_bank_chk

bind mat_flag_bank mat_flag_bank_chk #(.CHANNELS(CHANNELS)) u_mat_flag_bank_chk (
    .clk(clk), .rst(rst), .conv_done(conv_done), .meas(meas), .limit_high(limit_high),
    .limit_low(limit_low), .mask_table_a(mask_table_a), .mask_table_b(mask_table_b),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .masked_irq_out(masked_irq_out), .chan_valid(chan_valid));

// ===== verification/mat_flag_bank_tb.sv
// self-checking bench for the alarm and fast-trip flag bank
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end end
module mat_flag_bank_tb;
    logic clk, rst, reg_rd, reg_wr, mask_select, trip_latch_mode, reg_rvalid, masked_irq_out;
    logic [4:0] conv_done, trip_cmp, chan_valid;
    mat_pkg::mat_word_t [4:0] meas, limit_high, limit_low;
    logic [15:0] warn_flags;
    logic [31:0] mask_table_a, mask_table_b;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int n_fail, total_checks;
    typedef struct { int ch; logic [15:0] m; logic [7:0] pri; logic [7:0] sec; } mat_row_t;
    // one conversion per row with cumulative flag bytes; limits 0100 high, 0080 low
    mat_row_t rows [12] = '{'{0, 16'h0200, 8'h80, 8'h00}, '{0, 16'hff00, 8'h40, 8'h00},
        '{1, 16'h0200, 8'h60, 8'h00}, '{1, 16'h0010, 8'h50, 8'h00}, '{2, 16'h0200, 8'h58, 8'h00},
        '{3, 16'h0010, 8'h59, 8'h00}, '{4, 16'h0200, 8'h59, 8'h80}, '{4, 16'h0010, 8'h59, 8'h40},
        '{0, 16'h0100, 8'h19, 8'h40}, '{4, 16'h0080, 8'h19, 8'h00}, '{2, 16'h0000, 8'h15, 8'h00},
        '{3, 16'h0300, 8'h16, 8'h00}};

    mat_flag_bank u_mat_flag_bank (.clk(clk), .rst(rst), .conv_done(conv_done), .meas(meas),
        .limit_high(limit_high), .limit_low(limit_low), .warn_flags(warn_flags),
        .mask_table_a(mask_table_a), .mask_table_b(mask_table_b), .mask_select(mask_select),
        .trip_cmp(trip_cmp), .trip_latch_mode(trip_latch_mode), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .masked_irq_out(masked_irq_out), .chan_valid(chan_valid));

    ////////////////////////////////////////////////////////////////////////////
    // clock, closing task and bus tasks
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    // read one byte, also ends any conversion pulse; compares under a bit mask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        conv_done <= 5'h00;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK({reg_rvalid, reg_rdata & m}, {1'b1, e})
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic wait_irq(input logic e);
        repeat (3) @(posedge clk);
        #1 `CHK(masked_irq_out, e)
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst, reg_rd, reg_wr, mask_select, trip_latch_mode} = 5'h10;
        {conv_done, trip_cmp, warn_flags, reg_addr, reg_wdata} = '0;
        meas = '0;
        limit_high = {5{16'h0100}};
        limit_low = {5{16'h0080}};
        mask_table_a = '1;
        mask_table_b = '1;
        {n_fail, total_checks} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h73, 8'hff, 8'h00);
        rd_chk(8'h70, 8'hff, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            conv_done <= 5'h01 << rows[i].ch;
            meas[rows[i].ch] <= rows[i].m;
            rd_chk(8'h70, 8'hff, rows[i].pri);
            rd_chk(8'h71, 8'hc1, rows[i].sec);
        end
        $display("alarm rows done");
        wait_irq(1'b0);
        @(posedge clk) mask_table_a <= '0;
        wait_irq(1'b1);
        rd_chk(8'h71, 8'h01, 8'h01);
        @(posedge clk) mask_select <= 1'b1;
        wait_irq(1'b0);
        @(posedge clk);
        warn_flags <= 16'h0100;
        mask_table_b <= 32'hfeffffff;
        wait_irq(1'b1);
        $display("interrupt done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) trip_cmp <= 5'h01 << i;
            repeat (4) @(posedge clk);
            rd_chk(8'h73, 8'hff, 8'h01 << i);
        end
        @(posedge clk);
        trip_latch_mode <= 1'b1;
        trip_cmp <= 5'h1f;
        @(posedge clk) trip_cmp <= 5'h00;
        repeat (4) @(posedge clk);
        rd_chk(8'h73, 8'hff, 8'h1f);
        wr(8'h73, 8'hf0);
        rd_chk(8'h73, 8'hff, 8'h10);
        wr(8'h73, 8'h00);
        rd_chk(8'h73, 8'hff, 8'h00);
        // clear while the comparator still trips: the live trip wins
        @(posedge clk) trip_cmp <= 5'h01;
        repeat (4) @(posedge clk);
        wr(8'h73, 8'h00);
        rd_chk(8'h73, 8'hff, 8'h01);
        @(posedge clk) trip_cmp <= 5'h00;
        repeat (4) @(posedge clk);
        wr(8'h73, 8'h00);
        rd_chk(8'h73, 8'hff, 8'h00);
        wr(8'h70, 8'h00);
        rd_chk(8'h70, 8'hff, 8'h16);
        rd_chk(8'h6f, 8'hff, 8'h00);
        rd_chk(8'h72, 8'hff, 8'h00);
        $display("fast trip and refusals done");
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK(chan_valid, 5'h00)
        rd_chk(8'h70, 8'hff, 8'h00);
        $display("mid-run reset done");
        test_done();
    end

    // watchdog well beyond the roughly 170 cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule : mat_flag_bank_tb
